// File: pkg/rcs_pkg.sv
/*
 * Constants, packet layout and state type of the receiver control sequencer.
 * Assumes a 250 MHz system clock and packets delivered as 24-bit register writes
 * whose address is the packet id and whose data is bytes 2..0 of the packet.
 */
// Overview of operation
// RQ1 - set override bit forces line from packet
// RQ2 - cleared override bit returns line to sequencer
// RQ3 - twelve settings at packet ids 16 to 27
// RQ4 - setting packets ignored while decoding enabled
// RQ5 - off step time 8 bits, 625 us
// RQ6 - battery check samples input before leaving state
// RQ7 - lines show current state's line value
// RQ8 - warm-up codes 1 to 5 pick steps
// RQ9 - disabled warm-up step ends warm-up early
// RQ10 - warm-up step time 7 bits, 625 us
// RQ11 - sync wait precedes valid demod symbols
// RQ12 - codes 7,8,9 pick receiver-on settings
// RQ13 - enable bit7, check bit3, line, time bytes
// RQ14 - reset: time one unit, others zero
// RQ15 - lines undriven in reset, driven otherwise
// RQ16 - host loads settings only with decoding off
// RQ17 - order: off, warm-ups, sync, receiver on
// RQ18 - 625 us tick; zero step time invalid
package rcs_pkg;
    localparam int unsigned RCS_CLK_PERIOD_PS = 4000;
    localparam int unsigned RCS_TICK_TIME_PS  = 625000000;
    localparam int unsigned RCS_TICK_CYCLES   = RCS_TICK_TIME_PS / RCS_CLK_PERIOD_PS;
    localparam int unsigned RCS_TICK_W        = 18;

    localparam int unsigned RCS_ADDR_W = 8;
    localparam int unsigned RCS_DATA_W = 24;
    localparam int unsigned RCS_NSET   = 12;
    localparam int unsigned RCS_NWARM  = 5;

    // packet ids used as register addresses
    localparam logic [7:0] RCS_ID_CONTROL   = 8'h02;
    localparam logic [7:0] RCS_ID_LINE_CTRL = 8'h0f;
    localparam logic [7:0] RCS_ID_SET_FIRST = 8'h10;
    localparam logic [7:0] RCS_ID_SET_LAST  = 8'h1b;
    localparam logic [7:0] RCS_ID_STATUS    = 8'h40;
    localparam logic [7:0] RCS_ID_SEQ_CFG   = 8'h41;

    // setting indices (id minus first id)
    localparam logic [3:0] RCS_SET_OFF     = 4'h0;
    localparam logic [3:0] RCS_SET_WARM1   = 4'h1;
    localparam logic [3:0] RCS_SET_WARM5   = 4'h5;
    localparam logic [3:0] RCS_SET_SYNC32  = 4'h6;
    localparam logic [3:0] RCS_SET_SYNC16  = 4'h7;
    localparam logic [3:0] RCS_SET_DATA32  = 4'h8;
    localparam logic [3:0] RCS_SET_DATA16  = 4'h9;

    // field positions in the 24-bit packet body
    localparam int unsigned RCS_SE_BIT    = 23;
    localparam int unsigned RCS_LBC_BIT   = 19;
    localparam int unsigned RCS_LINE_LSB  = 8;
    localparam int unsigned RCS_ST_LSB    = 0;
    localparam int unsigned RCS_ON_BIT    = 0;

    localparam logic [7:0] RCS_ST_MASK_OFF  = 8'hff;
    localparam logic [7:0] RCS_ST_MASK_STEP = 8'h7f;
    localparam logic [7:0] RCS_ST_RESET     = 8'h01;
    localparam logic [7:0] RCS_BYTE_ZERO    = 8'h00;

    typedef enum logic [2:0] {
        RCS_IDLE,
        RCS_OFF,
        RCS_WARM,
        RCS_SYNC,
        RCS_ON
    } rcs_state_t;
endpackage : rcs_pkg

// File: logic/rcs_tick.sv
/*
 * 625 us tick divider with restart.
 * Assumes a synchronous active-low reset copy from the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_tick
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RCS_TICK_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output var  logic tick
);
    localparam logic [RCS_TICK_W-1:0] TOP = RCS_TICK_W'(TICK_CYCLES - 1);

    logic [RCS_TICK_W-1:0] cnt_r;

    // restart aligns the first tick of a step to a full period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (restart || cnt_r == TOP) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= !restart && cnt_r == TOP; // see RQ18
        end
    end
endmodule : rcs_tick
`default_nettype wire

// File: logic/rcs_step_timer.sv
/*
 * Step time counter counting 625 us ticks down to zero.
 * Assumes tick is a one-cycle pulse restarted together with load.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_step_timer (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       tick,
    output var  logic       done
);
    logic [7:0] cnt_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (load) begin
            // zero is not a legal code, run it as one unit
            cnt_r <= (load_val == 8'h00) ? 8'h01 : load_val; // see RQ18
        end else if (tick && cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= !load && tick && cnt_r == 8'h01;
        end
    end
endmodule : rcs_step_timer
`default_nettype wire

// File: logic/rcs_top.sv
/*
 * Receiver control sequencer: stores receiver settings, steps the eight
 * receiver control lines through off, warm-up, sync and receiver-on states,
 * and lets the host override single lines.
 * Assumes packets arrive as register writes on the plain register port and
 * that battery and demod inputs come from pins outside the clock domain.
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rcs_top
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RCS_TICK_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [RCS_ADDR_W-1:0] reg_addr,
    input  wire logic [RCS_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [RCS_DATA_W-1:0] reg_rdata,
    input  wire logic                  battery_low_input,
    input  wire logic                  demod_symbol_hi,
    input  wire logic                  demod_symbol_lo,
    output var  logic [7:0]            rx_ctrl_lines,
    output var  logic [7:0]            rx_ctrl_lines_oe,
    output var  logic                  symbols_valid,
    output var  logic                  demod_hi_out,
    output var  logic                  demod_lo_out,
    output var  logic                  battery_low_flag
);
    function automatic logic is_setting_id(input logic [7:0] id);
        is_setting_id = id >= RCS_ID_SET_FIRST && id <= RCS_ID_SET_LAST;
    endfunction : is_setting_id

    // step time field width per setting
    function automatic logic [7:0] st_mask(input logic [3:0] idx);
        if (idx == RCS_SET_OFF) begin
            st_mask = RCS_ST_MASK_OFF; // see RQ5
        end else if (idx <= RCS_SET_SYNC32) begin
            st_mask = RCS_ST_MASK_STEP; // see RQ10
        end else if (idx <= RCS_SET_DATA16) begin
            st_mask = RCS_BYTE_ZERO; // see RQ12
        end else begin
            st_mask = RCS_ST_MASK_STEP;
        end
    endfunction : st_mask

    function automatic logic has_enable(input logic [3:0] idx);
        has_enable = (idx >= RCS_SET_WARM1 && idx <= RCS_SET_WARM5) || idx > RCS_SET_DATA16;
    endfunction : has_enable

    // reset release and pin synchronisers
    logic       rst_s1_r;
    logic       rst_sync_n;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {battery_low_input, demod_symbol_hi, demod_symbol_lo};
            pin_s2_r <= pin_s1_r;
        end
    end

    wire logic bat_s   = pin_s2_r[2];
    wire logic sym_hi_s = pin_s2_r[1];
    wire logic sym_lo_s = pin_s2_r[0];

    // host-visible configuration
    logic                decode_on_r;
    logic [7:0]          force_line_override_r;
    logic [7:0]          force_value_r;
    logic [1:0]          on_select_r;
    logic [7:0]          line_value_r  [RCS_NSET];
    logic [7:0]          step_time_r   [RCS_NSET];
    logic [RCS_NSET-1:0] step_enable_r;
    logic [RCS_NSET-1:0] battery_check_r;

    wire logic wr_setting = reg_wr && is_setting_id(reg_addr) && !decode_on_r; // see RQ4
    wire logic [3:0] wr_idx = 4'(reg_addr - RCS_ID_SET_FIRST); // see RQ3

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            decode_on_r <= 1'b0;
            on_select_r <= 2'b00;
        end else if (reg_wr && reg_addr == RCS_ID_CONTROL) begin
            decode_on_r <= reg_wdata[RCS_ON_BIT];
        end else if (reg_wr && reg_addr == RCS_ID_SEQ_CFG) begin
            on_select_r <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            force_line_override_r <= 8'h00; // see RQ14
            force_value_r         <= 8'h00;
        end else if (reg_wr && reg_addr == RCS_ID_LINE_CTRL) begin
            force_line_override_r <= reg_wdata[RCS_LINE_LSB +: 8];
            force_value_r         <= reg_wdata[RCS_ST_LSB +: 8];
        end
    end

    genvar g;
    generate
        for (g = 0; g < RCS_NSET; g++) begin : g_set
            localparam logic [3:0] IDX = 4'(g);
            always_ff @(posedge sys_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    line_value_r[g]    <= 8'h00; // see RQ14
                    step_time_r[g]     <= RCS_ST_RESET;
                    step_enable_r[g]   <= 1'b0;
                    battery_check_r[g] <= 1'b0;
                end else if (wr_setting && wr_idx == IDX) begin
                    line_value_r[g]    <= reg_wdata[RCS_LINE_LSB +: 8]; // see RQ13
                    battery_check_r[g] <= reg_wdata[RCS_LBC_BIT];
                    step_enable_r[g]   <= has_enable(IDX) && reg_wdata[RCS_SE_BIT];
                    if (st_mask(IDX) != RCS_BYTE_ZERO) begin
                        step_time_r[g] <= reg_wdata[RCS_ST_LSB +: 8] & st_mask(IDX);
                    end
                end
            end
        end
    endgenerate

    // sequencer
    rcs_state_t state_r;
    rcs_state_t state_nxt;
    logic [3:0] cur_idx_r;
    logic [3:0] cur_idx_nxt;
    logic       step_load;
    logic       tick;
    logic       step_done;

    wire logic [3:0] on_idx = RCS_SET_SYNC16 + 4'(on_select_r == 2'b11 ? 2'b10 : on_select_r); // see RQ12
    wire logic [3:0] next_warm = cur_idx_r + 4'h1;
    wire logic next_warm_ok = (state_r == RCS_OFF) ? step_enable_r[RCS_SET_WARM1]
                            : (cur_idx_r < RCS_SET_WARM5 && step_enable_r[next_warm]);

    always_comb begin
        state_nxt   = state_r;
        cur_idx_nxt = cur_idx_r;
        step_load   = 1'b0;
        case (state_r)
            RCS_IDLE: begin
                cur_idx_nxt = RCS_SET_OFF;
                if (decode_on_r) begin
                    state_nxt = RCS_OFF; // see RQ17
                    step_load = 1'b1;
                end
            end
            RCS_OFF, RCS_WARM: begin
                if (step_done) begin
                    step_load = 1'b1;
                    if (next_warm_ok) begin
                        state_nxt   = RCS_WARM; // see RQ8
                        cur_idx_nxt = (state_r == RCS_OFF) ? RCS_SET_WARM1 : next_warm;
                    end else begin
                        state_nxt   = RCS_SYNC; // see RQ9
                        cur_idx_nxt = RCS_SET_SYNC32;
                    end
                end
            end
            RCS_SYNC: begin
                if (step_done) begin
                    state_nxt   = RCS_ON; // see RQ11
                    cur_idx_nxt = on_idx;
                end
            end
            RCS_ON: begin
                cur_idx_nxt = on_idx;
            end
            default: begin
                state_nxt   = RCS_IDLE;
                cur_idx_nxt = RCS_SET_OFF;
            end
        endcase
        // decoding off drops back to the receiver-off setting at once
        if (!decode_on_r && state_r != RCS_IDLE) begin
            state_nxt   = RCS_IDLE;
            cur_idx_nxt = RCS_SET_OFF;
            step_load   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r   <= RCS_IDLE;
            cur_idx_r <= RCS_SET_OFF;
        end else begin
            state_r   <= state_nxt;
            cur_idx_r <= cur_idx_nxt;
        end
    end

    rcs_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_sync_n),
        .restart (step_load),
        .tick    (tick)
    );

    rcs_step_timer u_timer (
        .sys_clk  (sys_clk),
        .rst_n    (rst_sync_n),
        .load     (step_load),
        .load_val (step_time_r[cur_idx_nxt]), // see RQ5
        .tick     (tick),
        .done     (step_done)
    );

    // battery sample taken in the last cycle of the state being left
    wire logic leaving = state_nxt != state_r || cur_idx_nxt != cur_idx_r;
    logic bat_taken_r;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            battery_low_flag <= 1'b0;
            bat_taken_r      <= 1'b0;
        end else if (leaving && state_r != RCS_IDLE && battery_check_r[cur_idx_r]) begin
            battery_low_flag <= bat_s; // see RQ6
            bat_taken_r      <= 1'b1;
        end
    end

    // symbols trusted only after the sync wait
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            symbols_valid <= 1'b0;
            demod_hi_out  <= 1'b0;
            demod_lo_out  <= 1'b0;
        end else begin
            symbols_valid <= state_nxt == RCS_ON; // see RQ11
            demod_hi_out  <= state_nxt == RCS_ON && sym_hi_s;
            demod_lo_out  <= state_nxt == RCS_ON && sym_lo_s;
        end
    end

    // control lines, per-line override
    wire logic [7:0] seq_line = line_value_r[cur_idx_nxt]; // see RQ7
    generate
        for (g = 0; g < 8; g++) begin : g_line
            always_ff @(posedge sys_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    rx_ctrl_lines[g]    <= 1'b0;
                    rx_ctrl_lines_oe[g] <= 1'b0; // see RQ15
                end else begin
                    rx_ctrl_lines[g]    <= force_line_override_r[g] ? force_value_r[g] // see RQ1
                                                                    : seq_line[g]; // see RQ2
                    rx_ctrl_lines_oe[g] <= 1'b1; // see RQ15
                end
            end
        end
    endgenerate

    // read port, data in the cycle after the strobe
    wire logic [3:0] rd_idx = 4'(reg_addr - RCS_ID_SET_FIRST);

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == RCS_ID_CONTROL) begin
                reg_rdata <= RCS_DATA_W'(decode_on_r);
            end else if (reg_addr == RCS_ID_LINE_CTRL) begin
                reg_rdata <= {RCS_BYTE_ZERO, force_line_override_r, force_value_r};
            end else if (is_setting_id(reg_addr)) begin
                reg_rdata <= {step_enable_r[rd_idx], 3'b000, battery_check_r[rd_idx], 3'b000,
                              line_value_r[rd_idx], step_time_r[rd_idx]};
            end else if (reg_addr == RCS_ID_STATUS) begin
                reg_rdata <= {8'h00, 4'h0, cur_idx_r, symbols_valid, bat_taken_r,
                              battery_low_flag, 2'b00, state_r};
            end else if (reg_addr == RCS_ID_SEQ_CFG) begin
                reg_rdata <= RCS_DATA_W'(on_select_r);
            end else begin
                reg_rdata <= '0;
            end
        end
    end
endmodule : rcs_top
`default_nettype wire

// File: dv/rcs_monitor.sv
/*
 * Port checker for rcs_top: reset release, idle lines, overrides, symbols.
 * Assumes binding into rcs_top.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_monitor
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 8
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [23:0] reg_rdata,
    input wire logic [7:0]  rx_ctrl_lines,
    input wire logic [7:0]  rx_ctrl_lines_oe,
    input wire logic        symbols_valid,
    input wire logic        demod_hi_out,
    input wire logic        demod_lo_out,
    input wire logic        battery_low_flag
);
    logic        dec_r;
    logic [7:0]  off_line_r;
    logic [7:0]  ov_mask_r;
    logic [7:0]  ov_val_r;
    logic [2:0]  wr_age_r;
    logic [2:0]  rel_cnt_r;
    logic [15:0] on_cnt_r;

    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_cnt_r <= 3'h0;
        end else if (rel_cnt_r != 3'h7) begin
            rel_cnt_r <= rel_cnt_r + 3'h1;
        end
    end

    // cycles since last write, skips settling
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_age_r <= 3'h0;
        end else if (reg_wr) begin
            wr_age_r <= 3'h0;
        end else if (wr_age_r != 3'h7) begin
            wr_age_r <= wr_age_r + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_r      <= 1'b0;
            off_line_r <= 8'h00;
            ov_mask_r  <= 8'h00;
            ov_val_r   <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == RCS_ID_CONTROL) begin
                dec_r <= reg_wdata[0];
            end
            if (reg_addr == RCS_ID_LINE_CTRL) begin
                ov_mask_r <= reg_wdata[15:8];
                ov_val_r  <= reg_wdata[7:0];
            end
            if (reg_addr == RCS_ID_SET_FIRST && !dec_r) begin
                off_line_r <= reg_wdata[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n || !dec_r) begin
            on_cnt_r <= 16'h0000;
        end else if (on_cnt_r != 16'hffff) begin
            on_cnt_r <= on_cnt_r + 16'h0001;
        end
    end

    oe_release_a: assert property (rel_cnt_r <= 3'h1 |-> rx_ctrl_lines_oe == 8'h00)
        else $error("lines driven in reset");
    oe_driven_a: assert property (rel_cnt_r >= 3'h3 |-> rx_ctrl_lines_oe == 8'hff)
        else $error("lines not driven after reset");
    idle_lines_a: assert property (!dec_r && wr_age_r >= 3'h3 |->
        rx_ctrl_lines == ((off_line_r & ~ov_mask_r) | (ov_val_r & ov_mask_r)))
        else $error("idle lines differ from off setting");
    override_hold_a: assert property (wr_age_r >= 3'h3 |-> ((rx_ctrl_lines ^ ov_val_r) & ov_mask_r) == 8'h00)
        else $error("forced line does not carry its value");
    sym_idle_a: assert property (!dec_r && wr_age_r >= 3'h3 |-> !symbols_valid)
        else $error("symbols valid while decoding off");
    bat_idle_a: assert property (!dec_r && wr_age_r >= 3'h4 |-> $stable(battery_low_flag))
        else $error("battery flag moved while idle");
    sync_wait_a: assert property ($rose(symbols_valid) |-> on_cnt_r >= 2 * TICK_CYCLES)
        else $error("symbols valid too early");
    demod_gate_a: assert property (!symbols_valid && !$past(symbols_valid) |->
        {demod_hi_out, demod_lo_out} == 2'b00)
        else $error("symbols passed while not valid");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved unread");

    cover property ($rose(symbols_valid));
    cover property (reg_wr && reg_addr == RCS_ID_LINE_CTRL && reg_wdata[15:8] != 8'h00);
    cover property (reg_wr && reg_addr == RCS_ID_SET_FIRST && dec_r);
endmodule : rcs_monitor

bind rcs_top rcs_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ctrl_lines(rx_ctrl_lines),
    .rx_ctrl_lines_oe(rx_ctrl_lines_oe), .symbols_valid(symbols_valid), .demod_hi_out(demod_hi_out),
    .demod_lo_out(demod_lo_out), .battery_low_flag(battery_low_flag));
`default_nettype wire

// File: dv/rcs_radio_model.sv
/*
 * Paging radio receiver as seen through its control lines.
 * Assumes powered means all lines driven, nonzero.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_radio_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] ctrl_lines,
    input  wire logic [7:0] ctrl_oe,
    input  wire logic       bat_low_cfg,
    output var  logic       battery_low,
    output var  logic       sym_hi,
    output var  logic       sym_lo
);
    logic [5:0] cnt_r = 6'h00;

    always_ff @(posedge sys_clk) begin
        cnt_r <= cnt_r + 6'h01;
    end

    // unpowered receiver gives noise, never a stale symbol
    always_comb begin
        if (ctrl_oe == 8'hff && ctrl_lines != 8'h00) begin
            {sym_hi, sym_lo} = cnt_r[5:4];
        end else begin
            {sym_hi, sym_lo} = cnt_r[1:0] ^ 2'b10;
        end
        battery_low = bat_low_cfg;
    end
endmodule : rcs_radio_model
`default_nettype wire

// File: dv/testbench.sv
/*
 * Self-checking bench for rcs_top and a radio model.
 * Assumes a short tick of TK cycles to keep runs short.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcs_pkg::*;
    localparam int TK = 8;
    logic        sys_clk, rst_n, reg_wr, reg_rd, bat_cfg, exp_bat;
    logic [7:0]  reg_addr, rx_ctrl_lines, rx_ctrl_lines_oe;
    logic [23:0] reg_wdata, reg_rdata;
    logic        battery_low_input, demod_symbol_hi, demod_symbol_lo;
    logic        symbols_valid, demod_hi_out, demod_lo_out, battery_low_flag;
    logic [23:0] sd [12];
    int          err_total, tests_run, cyc;

    rcs_top #(.TICK_CYCLES(TK)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .battery_low_input(battery_low_input),
        .demod_symbol_hi(demod_symbol_hi), .demod_symbol_lo(demod_symbol_lo), .rx_ctrl_lines(rx_ctrl_lines),
        .rx_ctrl_lines_oe(rx_ctrl_lines_oe), .symbols_valid(symbols_valid), .demod_hi_out(demod_hi_out),
        .demod_lo_out(demod_lo_out), .battery_low_flag(battery_low_flag));
    rcs_radio_model u_radio (
        .sys_clk(sys_clk), .ctrl_lines(rx_ctrl_lines), .ctrl_oe(rx_ctrl_lines_oe), .bat_low_cfg(bat_cfg),
        .battery_low(battery_low_input), .sym_hi(demod_symbol_hi), .sym_lo(demod_symbol_lo));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    // fields each setting keeps
    function automatic logic [23:0] fmask(input int k);
        if (k == 0) return 24'h08_ffff;
        if (k == 6) return 24'h08_ff7f;
        if (k >= 7 && k <= 9) return 24'h08_ff00;
        return 24'h88_ff7f;
    endfunction : fmask

    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic timed_out();
        err_total++;
        summarize();
    endtask : timed_out

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // slack for pipeline stages
    task automatic chk_dur(input int got, input int exp);
        tests_run++;
        if (got < exp - 2 || got > exp + 5) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_dur

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic chk_reg(input logic [7:0] a, input logic [23:0] m, input logic [23:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_val(reg_rdata & m, exp);
    endtask : chk_reg

    task automatic do_reset();
        int k;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cycles(3);
        chk_val(24'(rx_ctrl_lines_oe), 24'h00_0000);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        cycles(4);
        for (k = 0; k < 12; k++) begin
            sd[k] = 24'h00_0001 & fmask(k);
            chk_reg(RCS_ID_SET_FIRST + 8'(k), fmask(k), sd[k]);
        end
        chk_reg(8'h30, 24'hff_ffff, 24'h00_0000);
        exp_bat = 1'b0;
    endtask : do_reset

    task automatic run_seq(input int r);
        int          k, i, t0, n, dis;
        int          idx [$];
        logic [1:0]  sym;
        logic        lbc_seen;
        @(posedge sys_clk);
        bat_cfg <= 1'($urandom);
        dis = (r == 0) ? 3 : (r == 1) ? 6 : 1;
        for (k = 0; k < 12; k++) begin
            sd[k] = {1'(k != dis), 3'h0, 1'($urandom), 3'h0, 4'(k + 1), 4'($urandom), 8'($urandom_range(3, 1))};
            wr(RCS_ID_SET_FIRST + 8'(k), sd[k]);
            sd[k] = sd[k] & fmask(k);
        end
        for (k = 0; k < 12; k++) chk_reg(RCS_ID_SET_FIRST + 8'(k), fmask(k), sd[k]);
        wr(RCS_ID_SEQ_CFG, 24'(r));
        idx = {0};
        for (k = 1; k <= 5 && sd[k][23]; k++) idx.push_back(k);
        idx.push_back(6);
        idx.push_back(7 + r);
        lbc_seen = 1'b0;
        foreach (idx[j]) lbc_seen |= sd[idx[j]][19];
        if (lbc_seen) exp_bat = bat_cfg;
        wr(RCS_ID_CONTROL, 24'h00_0001);
        t0 = cyc;
        wr(RCS_ID_SET_FIRST, ~sd[0]);
        for (i = 1; i < idx.size(); i++) begin
            for (n = 0; rx_ctrl_lines === sd[idx[i - 1]][15:8] && n < 3000; n++) cycles(1);
            if (n == 3000) timed_out();
            chk_dur(cyc - t0, TK * int'(sd[idx[i - 1]][7:0]));
            t0 = cyc;
            chk_val(24'(rx_ctrl_lines), 24'(sd[idx[i]][15:8]));
        end
        cycles(4);
        chk_val(24'(symbols_valid), 24'h00_0001);
        sym = {demod_symbol_hi, demod_symbol_lo};
        for (n = 0; {demod_symbol_hi, demod_symbol_lo} === sym && n < 100; n++) cycles(1);
        if (n == 100) timed_out();
        cycles(6);
        chk_val(24'({demod_hi_out, demod_lo_out}), 24'({demod_symbol_hi, demod_symbol_lo}));
        wr(RCS_ID_CONTROL, 24'h00_0000);
        cycles(4);
        chk_val(24'(rx_ctrl_lines), 24'(sd[0][15:8]));
        chk_val(24'(symbols_valid), 24'h00_0000);
        chk_val(24'(battery_low_flag), 24'(exp_bat));
        chk_reg(RCS_ID_SET_FIRST, fmask(0), sd[0]);
    endtask : run_seq

    task automatic override_test();
        logic [7:0] m, v;
        m = 8'($urandom) | 8'h01;
        v = 8'($urandom);
        wr(RCS_ID_LINE_CTRL, {8'h00, m, v});
        cycles(3);
        chk_val(24'(rx_ctrl_lines), 24'((sd[0][15:8] & ~m) | (v & m)));
        wr(RCS_ID_LINE_CTRL, {16'h0000, v});
        cycles(3);
        chk_val(24'(rx_ctrl_lines), 24'(sd[0][15:8]));
    endtask : override_test

    initial begin
        rst_n     = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 24'h00_0000;
        bat_cfg   = 1'b0;
        void'($urandom(32'hd862_243b));
        do_reset();
        for (int r = 0; r < 3; r++) run_seq(r);
        override_test();
        do_reset();
        override_test();
        summarize();
    end
endmodule : testbench
`default_nettype wire
